// file: odaddr_core.sv
// operand resolution for relay groups, data, index and label devices
// Summary of operation
// - relay groups built four bits per digit
// - digit count 1-4 narrow, 1-8 wide
// - writes keep only bits that fit group
// - narrow group reads zero-fill upper bits
// - four-digit wide read has zero upper half
// - next group word starts right after previous
// - register word series uses consecutive registers
// - wide register pair: even low, next high
// - eight 16-bit, eight 32-bit index registers
// - indexed device number is head plus index
// - either index type indexes any width
// - index applies to relays, labels, groups, registers
// - digit count, jump label never indexed
// - register split general, file, special areas
// - file registers accessed like general registers
// - extension relays ascending, at most 48
// - declaration 1-4 frees home and jog terminals
// - withheld inputs unavailable for general use
// - backed areas flagged, file count from setup
`timescale 1ns/1ps
`default_nettype none
`include "odaddr_params.svh"
module odaddr_core import odaddr_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire odaddr_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [3:0] setup_parameter_general,
  input wire logic [11:0] setup_parameter_file_count,
  input wire logic [5:0] ext_input_count,
  input wire logic [5:0] ext_output_count,
  input wire logic [7:0] input_withheld,
  output odaddr_rsp_t rsp,
  output logic rsp_valid,
  output odaddr_bitreq_t bit_req,
  output logic bit_req_valid,
  input wire logic bit_rdata,
  output odaddr_wordreq_t word_req,
  output logic word_req_valid,
  input wire logic [15:0] word_rdata
);
  odaddr_state_t state;
  odaddr_req_t cur;
  logic [15:0] idx_v [`ODADDR_IDX_COUNT];
  logic [31:0] idx_z [`ODADDR_IDX_COUNT];
  logic [15:0] eff;
  logic [5:0] nbits;
  logic [5:0] cnt;
  logic [31:0] acc;
  logic err;
  logic hi_word;
  logic ext_fit;
  // sum kept one bit wider so two full counts cannot wrap back under the limit
  assign ext_fit = 7'(ext_input_count) + 7'(ext_output_count) <= 7'(`ODADDR_EXT_MAX);

  // relay bit availability; numbers are linear, shown to users in octal
  function automatic logic bit_ok(input odaddr_kind_t k, input logic [16:0] a);
    logic ok;
    logic [16:0] ext_end;
    ok = 1'b0;
    ext_end = 17'(`ODADDR_EXT_FIRST) + 17'(k == ODADDR_KIND_X ? ext_input_count
                                                                : ext_output_count);
    unique case (k)
      ODADDR_KIND_X: begin
        if (a <= 17'(`ODADDR_X_MAIN_LAST))
          ok = !input_withheld[a[2:0]];
        else if (a >= 17'(`ODADDR_EXT_FIRST) && a < ext_end &&
                 ext_fit)
          ok = 1'b1;
        else if (a >= 17'(`ODADDR_TERM_FIRST) && a <= 17'(`ODADDR_TERM_LAST))
          ok = setup_parameter_general >= `ODADDR_DECL_MIN &&
               setup_parameter_general <= `ODADDR_DECL_MAX;
      end
      ODADDR_KIND_Y: begin
        if (a <= 17'(`ODADDR_X_MAIN_LAST))
          ok = 1'b1;
        else if (a >= 17'(`ODADDR_EXT_FIRST) && a < ext_end &&
                 ext_fit)
          ok = 1'b1;
      end
      ODADDR_KIND_M: begin
        ok = a <= 17'(`ODADDR_M_GEN_LAST) ||
             (a >= 17'(`ODADDR_M_SPC_FIRST) && a <= 17'(`ODADDR_M_SPC_LAST));
      end
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // every bit of a group must exist, so a group never straddles a hole
  function automatic logic group_ok(input odaddr_kind_t k, input logic [15:0] h,
                                    input logic [5:0] n);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 32; i++) begin
      if (6'(i) < n && !bit_ok(k, 17'(h) + 17'(i)))
        ok = 1'b0;
    end
    return ok;
  endfunction

  // file registers past the configured count are not present
  function automatic logic reg_ok(input logic [16:0] a);
    logic ok;
    ok = a <= 17'(`ODADDR_D_GEN_LAST) ||
         (a >= 17'(`ODADDR_D_FILE_FIRST) &&
          a < 17'(`ODADDR_D_FILE_FIRST) + 17'(setup_parameter_file_count) &&
          a <= 17'(`ODADDR_D_FILE_LAST)) ||
         (a >= 17'(`ODADDR_D_SPC_FIRST) && a <= 17'(`ODADDR_D_SPC_LAST));
    return ok;
  endfunction

  logic [31:0] offset;
  logic [31:0] sum;
  logic [5:0] req_bits;
  logic nib_ok;
  logic is_group;
  logic next_err;
  logic next_backed;

  // a 16-bit index is sign-extended so a negative offset steps down
  always_comb begin
    offset = 32'h0000_0000;
    if (cur.idx.used && !(cur.kind == ODADDR_KIND_P && cur.is_jump)) begin
      if (cur.idx.is_z)
        offset = idx_z[cur.idx.num];
      else
        offset = {{16{idx_v[cur.idx.num][15]}}, idx_v[cur.idx.num]};
    end
  end

  assign sum = 32'(cur.head) + offset;
  assign is_group = cur.kind == ODADDR_KIND_X || cur.kind == ODADDR_KIND_Y ||
                    cur.kind == ODADDR_KIND_M;
  // the digit count is taken as written, never through the index
  assign req_bits = cur.single_bit ? 6'h01
                                   : 6'(cur.nibble_group_count) * `ODADDR_NIBBLE_BITS;
  // a zero count is refused, never read as sixteen groups
  assign nib_ok = cur.single_bit ||
                  (cur.nibble_group_count != 4'h0 &&
                   cur.nibble_group_count <= (cur.wide ? `ODADDR_MAX_NIB_WIDE
                                                       : `ODADDR_MAX_NIB_NARROW));

  always_comb begin
    // an offset sum past 16 bits is refused, never wrapped
    next_err = sum[31:16] != 16'h0000;
    next_backed = 1'b0;
    unique case (cur.kind)
      ODADDR_KIND_X, ODADDR_KIND_Y, ODADDR_KIND_M: begin
        next_err = next_err || !nib_ok || !group_ok(cur.kind, sum[15:0], req_bits);
        next_backed = cur.kind == ODADDR_KIND_M && sum[15:0] >= `ODADDR_M_BACK_FIRST &&
                      sum[15:0] <= `ODADDR_M_GEN_LAST;
      end
      ODADDR_KIND_D: begin
        next_err = next_err || !reg_ok(17'(sum[15:0])) ||
                   (cur.wide && (sum[0] || !reg_ok(17'(sum[15:0]) + 17'h1)));
        next_backed = sum[15:0] >= `ODADDR_D_BACK_FIRST &&
                      sum[15:0] <= `ODADDR_D_FILE_LAST;
      end
      ODADDR_KIND_V, ODADDR_KIND_Z: begin
        // an index register cannot itself be indexed
        next_err = cur.idx.used || cur.head >= 16'(`ODADDR_IDX_COUNT);
      end
      ODADDR_KIND_P: begin
        next_err = next_err || sum[15:0] > `ODADDR_P_LAST;
      end
      default: next_err = 1'b1;
    endcase
  end

  // sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ODADDR_IDLE;
    end else begin
      unique case (state)
        ODADDR_IDLE: begin
          if (req_valid)
            state <= ODADDR_RESOLVE;
        end
        ODADDR_RESOLVE: begin
          if (next_err || cur.kind == ODADDR_KIND_P || cur.kind == ODADDR_KIND_V ||
              cur.kind == ODADDR_KIND_Z)
            state <= ODADDR_FINISH;
          else if (is_group)
            state <= ODADDR_BIT_REQ;
          else
            state <= ODADDR_WORD_REQ;
        end
        ODADDR_BIT_REQ: state <= ODADDR_BIT_WAIT;
        ODADDR_BIT_WAIT: begin
          if (cnt + 6'h01 >= nbits)
            state <= ODADDR_FINISH;
          else
            state <= ODADDR_BIT_REQ;
        end
        ODADDR_WORD_REQ: state <= ODADDR_WORD_WAIT;
        ODADDR_WORD_WAIT: begin
          if (cur.wide && !hi_word)
            state <= ODADDR_WORD_REQ;
          else
            state <= ODADDR_FINISH;
        end
        ODADDR_FINISH: state <= ODADDR_IDLE;
        // a corrupted one-hot code falls back to idle rather than hanging
        default: state <= ODADDR_IDLE;
      endcase
    end
  end

  // request capture and resolution
  always_ff @(posedge clk) begin
    if (reset) begin
      cur <= '0;
      eff <= 16'h0000;
      nbits <= 6'h00;
      err <= 1'b0;
    end else if (state == ODADDR_IDLE && req_valid) begin
      cur <= req;
    end else if (state == ODADDR_RESOLVE) begin
      eff <= sum[15:0];
      nbits <= req_bits;
      err <= next_err;
    end
  end

  // bit and word walk, zero-filled accumulator
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt <= 6'h00;
      acc <= 32'h0000_0000;
      hi_word <= 1'b0;
    end else begin
      unique case (state)
        ODADDR_RESOLVE: begin
          cnt <= 6'h00;
          acc <= 32'h0000_0000;
          hi_word <= 1'b0;
        end
        ODADDR_BIT_WAIT: begin
          if (!cur.write)
            acc[cnt[4:0]] <= bit_rdata;
          cnt <= cnt + 6'h01;
        end
        ODADDR_WORD_WAIT: begin
          if (!cur.write) begin
            if (hi_word)
              acc[31:16] <= word_rdata;
            else
              acc[15:0] <= word_rdata;
          end
          hi_word <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // memory side strobes; only bits inside the group are ever written
  always_ff @(posedge clk) begin
    if (reset) begin
      bit_req <= '0;
      bit_req_valid <= 1'b0;
      word_req <= '0;
      word_req_valid <= 1'b0;
    end else begin
      bit_req_valid <= state == ODADDR_BIT_REQ;
      word_req_valid <= state == ODADDR_WORD_REQ;
      if (state == ODADDR_BIT_REQ) begin
        bit_req.space <= cur.kind[1:0];
        bit_req.write <= cur.write;
        bit_req.addr <= eff + 16'(cnt);
        bit_req.wbit <= cur.wdata[cnt[4:0]];
      end
      if (state == ODADDR_WORD_REQ) begin
        word_req.write <= cur.write;
        word_req.addr <= eff + {15'h0000, hi_word};
        word_req.wdata <= hi_word ? cur.wdata[31:16] : cur.wdata[15:0];
      end
    end
  end

  // index registers, read and written like ordinary registers
  // writes land at resolve, so the answer of the same request already sees them
  genvar g;
  for (g = 0; g < `ODADDR_IDX_COUNT; g++) begin : g_idx
    always_ff @(posedge clk) begin
      if (reset) begin
        idx_v[g] <= 16'h0000;
        idx_z[g] <= 32'h0000_0000;
      end else if (state == ODADDR_RESOLVE && !next_err && cur.write &&
                   cur.head == 16'(g)) begin
        if (cur.kind == ODADDR_KIND_V)
          idx_v[g] <= cur.wdata[15:0];
        if (cur.kind == ODADDR_KIND_Z)
          idx_z[g] <= cur.wide ? cur.wdata : {16'h0000, cur.wdata[15:0]};
      end
    end
  end

  // answer
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp <= '0;
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      // a request is taken whenever idle; ready only advertises that
      req_ready <= state == ODADDR_FINISH || (state == ODADDR_IDLE && !req_valid);
      rsp_valid <= state == ODADDR_FINISH;
      if (state == ODADDR_RESOLVE) begin
        rsp.backed <= next_backed;
        rsp.device <= sum[15:0];
      end
      if (state == ODADDR_FINISH) begin
        rsp.error <= err;
        // a refused operand answers zero so no stale data leaks out
        if (err)
          rsp.rdata <= 32'h0000_0000;
        else if (cur.kind == ODADDR_KIND_V)
          rsp.rdata <= {16'h0000, idx_v[cur.head[2:0]]};
        else if (cur.kind == ODADDR_KIND_Z)
          rsp.rdata <= cur.wide ? idx_z[cur.head[2:0]]
                                : {16'h0000, idx_z[cur.head[2:0]][15:0]};
        else if (cur.kind == ODADDR_KIND_P)
          rsp.rdata <= {16'h0000, eff};
        else
          rsp.rdata <= acc;
        if (is_group)
          rsp.next_head <= cur.head + 16'(nbits);
        else
          rsp.next_head <= cur.head + (cur.wide ? 16'h0002 : 16'h0001);
      end
    end
  end
endmodule
`default_nettype wire

// file: odaddr_core_sva.sv
// assertion checker for the operand device addressing core
`timescale 1ns/1ps
`default_nettype none
module odaddr_core_sva import odaddr_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire odaddr_req_t req,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire odaddr_rsp_t rsp,
  input wire logic rsp_valid,
  input wire odaddr_bitreq_t bit_req,
  input wire logic bit_req_valid,
  input wire odaddr_wordreq_t word_req,
  input wire logic word_req_valid
);
  logic [31:0] mask;
  logic take;
  logic grp;
  assign take = req_valid && req_ready;
  assign grp = req.kind inside {ODADDR_KIND_X, ODADDR_KIND_Y, ODADDR_KIND_M};
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // bits a read may set; writes are left unconstrained
  always_ff @(posedge clk) begin
    if (reset) begin
      mask <= 32'hFFFFFFFF;
    end else if (take) begin
      mask <= req.write ? 32'hFFFFFFFF : (grp && req.single_bit) ? 32'h00000001 :
        grp ? ~(32'hFFFFFFFF << {req.nibble_group_count, 2'b00}) :
        req.wide ? 32'hFFFFFFFF : 32'h0000FFFF;
    end
  end
  AST_COUNT_ZERO: assert property (
    take && grp && !req.single_bit && req.nibble_group_count == 4'h0 |->
    ##1 (!bit_req_valid)[*2] ##1 (rsp_valid && rsp.error))
    else $error("zero digit count not refused");
  AST_COUNT_HIGH: assert property (
    take && grp && !req.single_bit && req.nibble_group_count > (req.wide ? 4'h8 : 4'h4)
    |-> ##3 rsp_valid && rsp.error)
    else $error("digit count above limit not refused");
  AST_UPPER_ZERO: assert property (
    rsp_valid && !rsp.error |-> (rsp.rdata & ~mask) == 32'h00000000)
    else $error("bits above the group are not zero");
  AST_BIT_STEP: assert property (
    bit_req_valid ##2 bit_req_valid |-> bit_req.addr == $past(bit_req.addr, 2) + 16'h0001)
    else $error("relay bits not consecutive");
  AST_WORD_PAIR: assert property (
    word_req_valid ##2 word_req_valid |->
    word_req.addr == $past(word_req.addr, 2) + 16'h0001 && !$past(word_req.addr[0], 2))
    else $error("register pair not even then next");
  AST_INDEX_NUM: assert property (
    take && req.kind inside {ODADDR_KIND_V, ODADDR_KIND_Z} && req.head > 16'h0007
    |-> ##3 rsp_valid && rsp.error && rsp.rdata == 32'h00000000)
    else $error("index register number above seven accepted");
  AST_JUMP_LABEL: assert property (
    take && req.kind == ODADDR_KIND_P && req.is_jump && !req.write && req.head <= 16'h00FF
    |-> ##3 rsp_valid && rsp.rdata == {16'h0000, $past(req.head, 3)})
    else $error("jump label altered");
  AST_ERR_NOACC: assert property (
    rsp_valid && rsp.error |-> !$past(bit_req_valid) && !$past(word_req_valid))
    else $error("memory touched on refused operand");
  AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
endmodule
bind odaddr_core odaddr_core_sva sva (.clk(clk), .reset(reset), .req(req),
  .req_valid(req_valid), .req_ready(req_ready), .rsp(rsp), .rsp_valid(rsp_valid),
  .bit_req(bit_req), .bit_req_valid(bit_req_valid), .word_req(word_req),
  .word_req_valid(word_req_valid));
`default_nettype wire

// file: odaddr_core_tb.sv
// self-checking bench for the operand device addressing core
`timescale 1ns/1ps
`default_nettype none
module odaddr_core_tb import odaddr_pkg::*; ();
  logic clk, reset, req_valid, req_ready, rsp_valid, bit_req_valid, bit_rdata, word_req_valid;
  logic [15:0] word_rdata, rnd, h;
  logic [31:0] wd;
  logic [3:0] gen, n;
  logic [11:0] fcnt;
  logic [5:0] ext_i, ext_o;
  logic [7:0] held;
  odaddr_req_t req;
  odaddr_rsp_t rsp;
  odaddr_bitreq_t bit_req;
  odaddr_wordreq_t word_req;
  int errors, num_checks, cyc;
  odaddr_core dut (.clk(clk), .reset(reset), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .setup_parameter_general(gen), .setup_parameter_file_count(fcnt),
    .ext_input_count(ext_i), .ext_output_count(ext_o), .input_withheld(held), .rsp(rsp),
    .rsp_valid(rsp_valid), .bit_req(bit_req), .bit_req_valid(bit_req_valid),
    .bit_rdata(bit_rdata), .word_req(word_req), .word_req_valid(word_req_valid),
    .word_rdata(word_rdata));
  odaddr_mem_model mem (.clk(clk), .bit_req(bit_req), .bit_req_valid(bit_req_valid),
    .bit_rdata(bit_rdata), .word_req(word_req), .word_req_valid(word_req_valid),
    .word_rdata(word_rdata));
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] fit(input logic [31:0] v, input logic [3:0] k);
    return v & ~(32'hFFFFFFFF << {k, 2'b00});
  endfunction
  // input relay pattern preloaded below
  function automatic logic [31:0] xg(input int hd, input int nb);
    xg = 32'h00000000;
    for (int i = 0; i < nb; i++) xg[i] = 1'((hd + i) % 2 ^ ((hd + i) / 4) % 2);
  endfunction
  task automatic summarize();
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // f is {single_bit, wide, write, is_jump}, ix is {used, is_z, num}
  task automatic op(input odaddr_kind_t k, input logic [15:0] hd, input logic [3:0] c,
      input logic [3:0] f, input logic [4:0] ix, input logic [31:0] w);
    int i;
    tick();
    for (i = 0; i < 20 && req_ready !== 1'b1; i++) tick();
    req = '{k, hd, c, f[3], f[2], f[1], f[0], ix, w};
    req_valid = 1'b1;
    tick();
    req_valid = 1'b0;
    for (i = 0; i < 80 && rsp_valid !== 1'b1; i++) tick();
    chk("rsp_valid", 32'h1, 32'(rsp_valid));
  endtask
  task automatic ec(input odaddr_kind_t k, input logic [15:0] hd, input logic [3:0] c,
      input logic [3:0] f, input logic e);
    op(k, hd, c, f, 5'h00, 32'h00000000);
    chk("error", 32'(e), 32'(rsp.error));
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    {req_valid, req, gen, held} = '0;
    reset = 1'b1;
    rnd = 16'h0AF6;
    fcnt = 12'h00A;
    ext_i = 6'h08;
    ext_o = 6'h08;
    held = 8'h08;
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    for (int j = 0; j < 1024; j++) mem.bmem[0][j] = 1'(j % 2 ^ (j / 4) % 2);
    for (int j = 0; j < 12; j++) begin
      n = 4'(j % 8 + 1);
      rnd = nx(rnd);
      h = {8'h00, rnd[7:0]};
      wd = {rnd, nx(rnd)};
      op(ODADDR_KIND_M, h, n, {1'b0, j > 3, 2'b10}, 5'h00, wd);
      chk("bit", 32'(wd[4 * n - 1]), 32'(mem.bmem[2][h + 16'(4 * n) - 1]));
      op(ODADDR_KIND_M, h, n, {1'b0, j > 3, 2'b00}, 5'h00, 32'h00000000);
      chk("group", fit(wd, n), rsp.rdata);
      chk("next", 32'(h + 16'(4 * n)), 32'(rsp.next_head));
    end
    h = {5'h00, rnd[10:1], 1'b0} + 16'h0064;
    op(ODADDR_KIND_D, h, 4'h0, 4'b0110, 5'h00, wd);
    chk("low", 32'(wd[15:0]), 32'(mem.wmem[h]));
    chk("high", 32'(wd[31:16]), 32'(mem.wmem[h + 16'h0001]));
    op(ODADDR_KIND_D, h, 4'h0, 4'b0100, 5'h00, 32'h00000000);
    chk("wide", wd, rsp.rdata);
    op(ODADDR_KIND_D, h + 16'h0001, 4'h0, 4'b0000, 5'h00, 32'h00000000);
    chk("narrow", 32'(wd[31:16]), rsp.rdata);
    chk("series", 32'(h + 16'h0002), 32'(rsp.next_head));
    chk("backed", 32'h1, 32'(rsp.backed));
    ec(ODADDR_KIND_D, h + 16'h0001, 4'h0, 4'b0100, 1'b1);
    ec(ODADDR_KIND_D, 16'h0FA9, 4'h0, 4'b0000, 1'b0);
    ec(ODADDR_KIND_D, 16'h0FAA, 4'h0, 4'b0000, 1'b1);
    ec(ODADDR_KIND_D, 16'h1F40, 4'h0, 4'b0000, 1'b1);
    ec(ODADDR_KIND_D, 16'h257F, 4'h0, 4'b0000, 1'b0);
    ec(ODADDR_KIND_D, 16'h2580, 4'h0, 4'b0000, 1'b1);
    ec(ODADDR_KIND_M, 16'h0000, 4'h0, 4'b0000, 1'b1);
    ec(ODADDR_KIND_M, 16'h0000, 4'h5, 4'b0000, 1'b1);
    ec(ODADDR_KIND_M, 16'h0000, 4'h9, 4'b0100, 1'b1);
    ec(ODADDR_KIND_V, 16'h0009, 4'h0, 4'b0000, 1'b1);
    ec(ODADDR_KIND_X, 16'h0008, 4'h0, 4'b1000, 1'b0);
    ec(ODADDR_KIND_X, 16'h0010, 4'h0, 4'b1000, 1'b1);
    ec(ODADDR_KIND_X, 16'h0003, 4'h0, 4'b1000, 1'b1);
    ec(ODADDR_KIND_X, 16'h00FA, 4'h0, 4'b1000, 1'b1);
    gen = 4'h1;
    ec(ODADDR_KIND_X, 16'h00FA, 4'h0, 4'b1000, 1'b0);
    op(ODADDR_KIND_X, 16'h0008, 4'h2, 4'b0000, 5'h00, 32'h00000000);
    chk("octal", xg(8, 8), rsp.rdata);
    op(ODADDR_KIND_Y, 16'h0000, 4'h2, 4'b0010, 5'h00, 32'h0000013C);
    op(ODADDR_KIND_Y, 16'h0000, 4'h2, 4'b0000, 5'h00, 32'h00000000);
    chk("output", 32'h0000003C, rsp.rdata);
    ext_i = 6'h28;
    ext_o = 6'h10;
    ec(ODADDR_KIND_X, 16'h0008, 4'h0, 4'b1000, 1'b1);
    ec(ODADDR_KIND_Y, 16'h0008, 4'h0, 4'b1000, 1'b1);
    op(ODADDR_KIND_V, 16'h0001, 4'h0, 4'b0010, 5'h00, 32'h00000008);
    op(ODADDR_KIND_Z, 16'h0002, 4'h0, 4'b0110, 5'h00, 32'h0000000A);
    op(ODADDR_KIND_V, 16'h0001, 4'h0, 4'b0000, 5'h00, 32'h00000000);
    chk("index", 32'h00000008, rsp.rdata);
    op(ODADDR_KIND_Z, 16'h0002, 4'h0, 4'b0100, 5'h00, 32'h00000000);
    chk("zindex", 32'h0000000A, rsp.rdata);
    op(ODADDR_KIND_V, 16'h0001, 4'h0, 4'b0000, 5'h11, 32'h00000000);
    chk("refused", 32'h1, 32'(rsp.error));
    chk("zero", 32'h0, rsp.rdata);
    op(ODADDR_KIND_D, 16'h0004, 4'h0, 4'b0000, 5'h11, 32'h00000000);
    chk("device", 32'h0000000C, 32'(rsp.device));
    chk("backed", 32'h0, 32'(rsp.backed));
    op(ODADDR_KIND_D, 16'h0002, 4'h0, 4'b0100, 5'h1A, 32'h00000000);
    chk("device", 32'h0000000C, 32'(rsp.device));
    op(ODADDR_KIND_V, 16'h0003, 4'h0, 4'b0010, 5'h00, 32'h0000FFFC);
    op(ODADDR_KIND_D, 16'h0010, 4'h0, 4'b0000, 5'h13, 32'h00000000);
    chk("device", 32'h0000000C, 32'(rsp.device));
    mem.bmem[2][16] = 1'b0;
    op(ODADDR_KIND_M, 16'h0000, 4'h2, 4'b0010, 5'h11, 32'h000001A5);
    op(ODADDR_KIND_M, 16'h0008, 4'h2, 4'b0000, 5'h00, 32'h00000000);
    chk("group", 32'h000000A5, rsp.rdata);
    chk("count", 32'h0, 32'(mem.bmem[2][16]));
    op(ODADDR_KIND_P, 16'h0005, 4'h0, 4'b0001, 5'h11, 32'h00000000);
    chk("jump", 32'h00000005, rsp.rdata);
    op(ODADDR_KIND_P, 16'h0005, 4'h0, 4'b0000, 5'h11, 32'h00000000);
    chk("label", 32'h0000000D, rsp.rdata);
    op(ODADDR_KIND_P, 16'h00FF, 4'h0, 4'b0000, 5'h11, 32'h00000000);
    chk("error", 32'h1, 32'(rsp.error));
    chk("label", 32'h0, rsp.rdata);
    summarize();
  end
endmodule
`default_nettype wire

// file: odaddr_mem_model.sv
// relay and register memories answering the core's bit and word requests
`timescale 1ns/1ps
`default_nettype none
module odaddr_mem_model import odaddr_pkg::*; (
  input wire logic clk,
  input wire odaddr_bitreq_t bit_req,
  input wire logic bit_req_valid,
  output logic bit_rdata,
  input wire odaddr_wordreq_t word_req,
  input wire logic word_req_valid,
  output logic [15:0] word_rdata
);
  logic bmem [0:3][0:1023];
  logic [15:0] wmem [0:16383];
  logic bq = 1'b0;
  logic [15:0] wq = 16'h0000;
  // data held one cycle after a request, then toggling so a late sample is caught
  assign bit_rdata = bit_req_valid ? bmem[bit_req.space][bit_req.addr[9:0]] : bq;
  assign word_rdata = word_req_valid ? wmem[word_req.addr[13:0]] : wq;
  initial begin
    for (int i = 0; i < 16384; i++) wmem[i] = 16'h0000;
    for (int i = 0; i < 4096; i++) bmem[i / 1024][i % 1024] = 1'b0;
  end
  always @(posedge clk) begin
    bq <= bit_req_valid ? bit_rdata : ~bit_rdata;
    wq <= word_req_valid ? word_rdata : ~word_rdata;
    if (bit_req_valid && bit_req.write) bmem[bit_req.space][bit_req.addr[9:0]] <= bit_req.wbit;
    if (word_req_valid && word_req.write) wmem[word_req.addr[13:0]] <= word_req.wdata;
  end
endmodule
`default_nettype wire

// file: odaddr_params.svh
// constants for operand device addressing
`ifndef ODADDR_PARAMS_SVH
`define ODADDR_PARAMS_SVH
`define ODADDR_NIBBLE_BITS 6'h04
`define ODADDR_MAX_NIB_NARROW 4'h4
`define ODADDR_MAX_NIB_WIDE 4'h8
`define ODADDR_X_MAIN_LAST 16'h0007
`define ODADDR_EXT_FIRST 16'h0008
`define ODADDR_EXT_MAX 6'h30
`define ODADDR_TERM_FIRST 16'h00FA
`define ODADDR_TERM_LAST 16'h00FF
`define ODADDR_M_GEN_LAST 16'h01FF
`define ODADDR_M_BACK_FIRST 16'h0064
`define ODADDR_M_SPC_FIRST 16'h2328
`define ODADDR_M_SPC_LAST 16'h23D7
`define ODADDR_D_GEN_LAST 16'h0F9F
`define ODADDR_D_BACK_FIRST 16'h0064
`define ODADDR_D_FILE_FIRST 16'h0FA0
`define ODADDR_D_FILE_LAST 16'h1B57
`define ODADDR_D_SPC_FIRST 16'h2328
`define ODADDR_D_SPC_LAST 16'h257F
`define ODADDR_P_LAST 16'h00FF
`define ODADDR_IDX_COUNT 8
`define ODADDR_DECL_MIN 4'h1
`define ODADDR_DECL_MAX 4'h4
`endif

// file: odaddr_pkg.sv
// types for operand device addressing
package odaddr_pkg;
  typedef enum logic [2:0] {
    ODADDR_KIND_X = 3'h0,
    ODADDR_KIND_Y = 3'h1,
    ODADDR_KIND_M = 3'h2,
    ODADDR_KIND_D = 3'h3,
    ODADDR_KIND_V = 3'h4,
    ODADDR_KIND_Z = 3'h5,
    ODADDR_KIND_P = 3'h6
  } odaddr_kind_t;

  typedef struct packed {
    logic used;
    logic is_z;
    logic [2:0] num;
  } odaddr_idx_t;

  typedef struct packed {
    odaddr_kind_t kind;
    logic [15:0] head;
    logic [3:0] nibble_group_count;
    logic single_bit;
    logic wide;
    logic write;
    logic is_jump;
    odaddr_idx_t idx;
    logic [31:0] wdata;
  } odaddr_req_t;

  typedef struct packed {
    logic error;
    logic backed;
    logic [31:0] rdata;
    logic [15:0] device;
    logic [15:0] next_head;
  } odaddr_rsp_t;

  typedef struct packed {
    logic [1:0] space;
    logic write;
    logic [15:0] addr;
    logic wbit;
  } odaddr_bitreq_t;

  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } odaddr_wordreq_t;

  typedef enum logic [6:0] {
    ODADDR_IDLE = 7'h01,
    ODADDR_RESOLVE = 7'h02,
    ODADDR_BIT_REQ = 7'h04,
    ODADDR_BIT_WAIT = 7'h08,
    ODADDR_WORD_REQ = 7'h10,
    ODADDR_WORD_WAIT = 7'h20,
    ODADDR_FINISH = 7'h40
  } odaddr_state_t;
endpackage
